// ---- hw/crs_pkg.sv ----
package crs_pkg;
  // register addresses on the host register port
  localparam logic [7:0] ADDR_HOST_INPUT = 8'h0A;
  localparam logic [7:0] ADDR_COMMAND_CODE = 8'h0B;
  localparam logic [7:0] ADDR_IRQ_ENABLE_MASK = 8'h0F;
  localparam logic [7:0] ADDR_PARAM_READBACK = 8'h10;
  localparam logic [7:0] ADDR_COMMAND_STATUS = 8'h11;
  // reset values
  localparam logic [7:0] RST_HOST_INPUT = 8'h00;
  localparam logic [7:0] RST_COMMAND_CODE = 8'h00;
  localparam logic [7:0] RST_IRQ_ENABLE_MASK = 8'h00;
  localparam logic [7:0] RST_PARAM_READBACK = 8'h00;
  localparam logic [7:0] RST_PARAM_ENTRY = 8'h00;
  localparam logic [3:0] RST_COMMAND_COUNTER = 4'hF;
  localparam logic [3:0] CLR_COMMAND_COUNTER = 4'h0;
  localparam logic [7:0] RD_UNMAPPED = 8'h00;
  // command_status field positions
  localparam int STAT_RUNNING_BIT = 7;
  localparam int STAT_SUSPEND_BIT = 6;
  localparam int STAT_SLEEP_BIT = 5;
  localparam int STAT_ERR_BIT = 4;
  // error codes as seen in bits 4:0 while the error flag is set
  localparam logic [4:0] ERR_INVALID_CMD = 5'h10;
  localparam logic [4:0] ERR_BAD_PARAM = 5'h11;
  localparam logic [4:0] ERR_SATURATION = 5'h12;
  localparam logic [4:0] ERR_OUT_OVERFLOW = 5'h13;
  // command encodings
  localparam logic [7:0] CMD_COUNTER_CLEAR = 8'h00;
  localparam logic [7:0] CMD_SOFT_RESET = 8'h01;
  localparam logic [1:0] CMD_OP_PARAM_QUERY = 2'h1;
  localparam logic [1:0] CMD_OP_PARAM_SET = 2'h2;
  // parameter table and output field sizes
  localparam int PARAM_ADDR_W = 6;
  localparam int PARAM_DEPTH = 44;
  localparam logic [5:0] OUT_FIELD_BYTES = 6'h1A;
  // timing
  localparam int CLK_PERIOD_NS = 20;
  localparam int INIT_TIME_NS = 1000;
  localparam int INIT_CYCLES = (INIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // processor state, gray coded along boot -> sleep -> exec -> sleep
  typedef enum logic [1:0] {
    CRS_BOOT = 2'h0,
    CRS_SLEEP = 2'h1,
    CRS_EXEC = 2'h3,
    CRS_SUSP = 2'h2
  } crs_state_e;
endpackage

// ---- hw/crs_init_timer.sv ----
`timescale 1ns/10ps
module crs_init_timer #(
  parameter int CYCLES = crs_pkg::INIT_CYCLES
) (
  input wire logic clk_sys, // system clock
  input wire logic arst_n, // async reset, active low
  input wire logic restart, // restart the initialization delay
  output logic done_q // high once the delay has elapsed
);
  localparam int CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

  logic [CW-1:0] cnt_q;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q <= '0;
      done_q <= 1'b0;
    end else if (restart) begin
      cnt_q <= '0;
      done_q <= 1'b0;
    end else if (!done_q) begin
      if (cnt_q == LAST) begin
        done_q <= 1'b1;
      end else begin
        cnt_q <= cnt_q + 1'b1;
      end
    end
  end
endmodule // crs_init_timer

// ---- hw/crs_core.sv ----
// What this block does
// - hard or soft reset clears command code and interrupt enable registers.
// - parameter write copies the stored byte into the readback register.
// - parameter read places the fetched table byte into the readback register.
// - error flag cleared by power-up, soft reset and counter clear command.
// - invalid commands set the error flag; counter field then carries error code.
// - invalid command reports 0x10, invalid parameter location reports 0x11.
// - converter saturation or accumulation overflow reports 0x12.
// - repeated mode producing more than 26 output bytes reports 0x13.
// - without error, counter increments once per successful written command.
// - counter clear command sets the counter to zero.
// - power-up or soft reset loads the counter with all ones.
// - top three status bits show running, suspended, sleeping.
// - running right after reset, sleeping once initialization completes.
// - counter clear command touches only the counter field and the error flag.
`timescale 1ns/10ps
module crs_core #(
  parameter int DEPTH = crs_pkg::PARAM_DEPTH,
  parameter int INIT_CYCLES = crs_pkg::INIT_CYCLES
) (
  input wire logic clk_sys, // system clock, 50 MHz
  input wire logic arst_n, // async reset, active low
  input wire logic [7:0] reg_addr, // register address
  input wire logic reg_wr, // register write strobe
  input wire logic [7:0] reg_wdata, // register write data
  input wire logic reg_rd, // register read strobe
  input wire logic suspend_req, // measurement engine holds the core suspended
  input wire logic sat_evt, // converter saturation or accumulation overflow
  input wire logic burst_en, // repeated-measurement mode enabled
  input wire logic [5:0] burst_bytes, // configured output bytes per burst
  output logic [7:0] reg_rdata_q, // read data, valid the cycle after reg_rd
  output logic [7:0] irq_enable_q, // interrupt enable mask to interrupt logic
  output logic cmd_done_q // pulse when a command completes
);
  logic [7:0] host_input_q;
  logic [7:0] command_code_q;
  logic [7:0] param_readback_q;
  logic [3:0] command_counter_q;
  logic cmd_err_q;
  logic [4:0] err_code_q;
  logic cmd_pend_q;
  logic soft_rst_q;
  logic init_done;
  logic exec;
  logic [7:0] ptab_q [DEPTH];
  crs_pkg::crs_state_e state_q;
  crs_pkg::crs_state_e state_d;

  // command decode
  logic [1:0] cmd_op;
  logic [crs_pkg::PARAM_ADDR_W-1:0] cmd_idx;
  logic idx_ok;
  logic is_clear;
  logic is_reset;
  logic is_query;
  logic is_set;
  logic is_bad;
  logic ovf_now;
  logic ovf_q;
  logic err_evt;
  logic [4:0] err_evt_code;
  logic [7:0] status_byte;
  logic wr_hin;
  logic wr_cmd;
  logic wr_irq;
  logic cmd_good;

  assign cmd_op = command_code_q[7:6];
  assign cmd_idx = command_code_q[crs_pkg::PARAM_ADDR_W-1:0];
  assign idx_ok = (32'(cmd_idx) < DEPTH);
  assign is_clear = (command_code_q == crs_pkg::CMD_COUNTER_CLEAR);
  assign is_reset = (command_code_q == crs_pkg::CMD_SOFT_RESET);
  assign is_query = (cmd_op == crs_pkg::CMD_OP_PARAM_QUERY);
  assign is_set = (cmd_op == crs_pkg::CMD_OP_PARAM_SET);
  assign is_bad = !(is_clear || is_reset || is_query || is_set);
  assign exec = (state_q == crs_pkg::CRS_EXEC);
  assign ovf_now = burst_en && (burst_bytes > crs_pkg::OUT_FIELD_BYTES);
  // register write decodes
  assign wr_hin = reg_wr && (reg_addr == crs_pkg::ADDR_HOST_INPUT);
  assign wr_cmd = reg_wr && (reg_addr == crs_pkg::ADDR_COMMAND_CODE);
  assign wr_irq = reg_wr && (reg_addr == crs_pkg::ADDR_IRQ_ENABLE_MASK);
  // a command counts only when it executes cleanly with no error pending
  assign cmd_good = exec && !is_reset && !err_evt && !cmd_err_q;

  crs_init_timer #(
    .CYCLES(INIT_CYCLES)
  ) u_init (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .restart(soft_rst_q),
    .done_q(init_done)
  );

  // error sources in priority order; the first code stays until cleared
  always_comb begin
    err_evt = 1'b0;
    err_evt_code = crs_pkg::ERR_INVALID_CMD;
    if (exec && is_bad) begin
      err_evt = 1'b1;
      err_evt_code = crs_pkg::ERR_INVALID_CMD;
    end else if (exec && (is_query || is_set) && !idx_ok) begin
      err_evt = 1'b1;
      err_evt_code = crs_pkg::ERR_BAD_PARAM;
    end else if (sat_evt) begin
      err_evt = 1'b1;
      err_evt_code = crs_pkg::ERR_SATURATION;
    end else if (ovf_now && !ovf_q) begin
      err_evt = 1'b1;
      err_evt_code = crs_pkg::ERR_OUT_OVERFLOW;
    end
  end

  // processor state
  always_comb begin
    state_d = state_q;
    case (state_q)
      crs_pkg::CRS_BOOT: begin
        if (init_done) begin
          state_d = crs_pkg::CRS_SLEEP;
        end
      end
      crs_pkg::CRS_SLEEP: begin
        if (suspend_req) begin
          state_d = crs_pkg::CRS_SUSP;
        end else if (cmd_pend_q) begin
          state_d = crs_pkg::CRS_EXEC;
        end
      end
      crs_pkg::CRS_EXEC: begin
        state_d = is_reset ? crs_pkg::CRS_BOOT : crs_pkg::CRS_SLEEP;
      end
      crs_pkg::CRS_SUSP: begin
        if (!suspend_req) begin
          state_d = crs_pkg::CRS_SLEEP;
        end
      end
      default: begin
        state_d = crs_pkg::CRS_BOOT;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= crs_pkg::CRS_BOOT;
    end else if (soft_rst_q) begin
      state_q <= crs_pkg::CRS_BOOT;
    end else begin
      state_q <= state_d;
    end
  end

  // soft reset is applied one cycle after the command executes
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      soft_rst_q <= 1'b0;
    end else begin
      soft_rst_q <= exec && is_reset;
    end
  end

  // host writable registers
  // writes to read-only or unmapped addresses fall through untouched
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      host_input_q <= crs_pkg::RST_HOST_INPUT;
      command_code_q <= crs_pkg::RST_COMMAND_CODE;
      irq_enable_q <= crs_pkg::RST_IRQ_ENABLE_MASK;
      cmd_pend_q <= 1'b0;
    end else if (soft_rst_q) begin
      host_input_q <= crs_pkg::RST_HOST_INPUT;
      command_code_q <= crs_pkg::RST_COMMAND_CODE;
      irq_enable_q <= crs_pkg::RST_IRQ_ENABLE_MASK;
      cmd_pend_q <= 1'b0;
    end else begin
      if (wr_hin) begin
        host_input_q <= reg_wdata;
      end
      if (wr_irq) begin
        irq_enable_q <= reg_wdata;
      end
      // a new command write wins over completion of the previous one
      // commands written in boot or suspend wait here until sleep
      if (wr_cmd) begin
        command_code_q <= reg_wdata;
        cmd_pend_q <= 1'b1;
      end else if (exec) begin
        cmd_pend_q <= 1'b0;
      end
    end
  end

  // parameter table
  // every entry returns to its default on either reset
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < DEPTH; i++) begin
        ptab_q[i] <= crs_pkg::RST_PARAM_ENTRY;
      end
    end else if (soft_rst_q) begin
      for (int i = 0; i < DEPTH; i++) begin
        ptab_q[i] <= crs_pkg::RST_PARAM_ENTRY;
      end
    end else if (exec && is_set && idx_ok) begin
      ptab_q[cmd_idx] <= host_input_q;
    end
  end

  // readback register
  // an out-of-range index leaves the readback value as it was
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      param_readback_q <= crs_pkg::RST_PARAM_READBACK;
    end else if (soft_rst_q) begin
      param_readback_q <= crs_pkg::RST_PARAM_READBACK;
    end else if (exec && idx_ok) begin
      if (is_set) begin
        param_readback_q <= host_input_q;
      end else if (is_query) begin
        param_readback_q <= ptab_q[cmd_idx];
      end
    end
  end

  // overflow condition edge memory
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      ovf_q <= 1'b0;
    end else begin
      ovf_q <= ovf_now;
    end
  end

  // error flag and code; a new error wins over a clear in the same cycle
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      cmd_err_q <= 1'b0;
      err_code_q <= crs_pkg::ERR_INVALID_CMD;
    end else if (soft_rst_q) begin
      cmd_err_q <= 1'b0;
      err_code_q <= crs_pkg::ERR_INVALID_CMD;
    end else if (err_evt && !cmd_err_q) begin
      cmd_err_q <= 1'b1;
      err_code_q <= err_evt_code;
    end else if (exec && is_clear && !err_evt) begin
      cmd_err_q <= 1'b0;
    end
  end

  // command counter
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      command_counter_q <= crs_pkg::RST_COMMAND_COUNTER;
    end else if (soft_rst_q) begin
      command_counter_q <= crs_pkg::RST_COMMAND_COUNTER;
    end else if (exec && is_clear) begin
      command_counter_q <= crs_pkg::CLR_COMMAND_COUNTER;
    end else if (cmd_good) begin
      command_counter_q <= command_counter_q + 4'h1;
    end
  end

  // completion pulse; a soft reset completes when its reset is applied
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      cmd_done_q <= 1'b0;
    end else begin
      cmd_done_q <= exec && !is_reset || soft_rst_q;
    end
  end

  always_comb begin
    status_byte = 8'h00;
    status_byte[crs_pkg::STAT_RUNNING_BIT] = (state_q == crs_pkg::CRS_BOOT) || exec;
    status_byte[crs_pkg::STAT_SUSPEND_BIT] = (state_q == crs_pkg::CRS_SUSP);
    status_byte[crs_pkg::STAT_SLEEP_BIT] = (state_q == crs_pkg::CRS_SLEEP);
    // the counter stays underneath an error code and reappears once cleared
    if (cmd_err_q) begin
      status_byte[4:0] = err_code_q;
    end else begin
      status_byte[3:0] = command_counter_q;
    end
  end

  // register read port
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata_q <= crs_pkg::RD_UNMAPPED;
    end else if (reg_rd) begin
      case (reg_addr)
        crs_pkg::ADDR_HOST_INPUT: reg_rdata_q <= host_input_q;
        crs_pkg::ADDR_COMMAND_CODE: reg_rdata_q <= command_code_q;
        crs_pkg::ADDR_IRQ_ENABLE_MASK: reg_rdata_q <= irq_enable_q;
        crs_pkg::ADDR_PARAM_READBACK: reg_rdata_q <= param_readback_q;
        crs_pkg::ADDR_COMMAND_STATUS: reg_rdata_q <= status_byte;
        default: reg_rdata_q <= crs_pkg::RD_UNMAPPED;
      endcase
    end
  end
endmodule // crs_core

// ---- test/crs_core_monitor.sv ----
`timescale 1ns/10ps
module crs_core_monitor #(
  parameter int DEPTH = crs_pkg::PARAM_DEPTH,
  parameter int INIT_CYCLES = crs_pkg::INIT_CYCLES
) (
  input wire logic clk_sys, // clock
  input wire logic arst_n, // reset
  input wire logic [7:0] reg_addr, // addr
  input wire logic reg_wr, // write
  input wire logic [7:0] reg_wdata, // wdata
  input wire logic reg_rd, // read
  input wire logic suspend_req, // suspend
  input wire logic sat_evt, // saturation
  input wire logic burst_en, // burst
  input wire logic [5:0] burst_bytes, // burst size
  input wire logic [7:0] reg_rdata_q, // rdata
  input wire logic [7:0] irq_enable_q, // irq mask
  input wire logic cmd_done_q // done
);
  logic [7:0] cyc_q;
  wire st_rd = reg_rd && reg_addr == crs_pkg::ADDR_COMMAND_STATUS;
  wire boot_rd = st_rd && int'(cyc_q) < INIT_CYCLES - 3;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  // cycles since hard reset release, saturating
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      cyc_q <= 8'h00;
    end else if (cyc_q != 8'hFF) begin
      cyc_q <= cyc_q + 8'h01;
    end
  end
  property p_rst_irq; $rose(arst_n) |-> irq_enable_q == 8'h00; endproperty
  a_rst_irq: assert property (p_rst_irq) else $error("irq mask not clear");
  property p_rst_rdata; $rose(arst_n) |-> reg_rdata_q == 8'h00 && !cmd_done_q; endproperty
  a_rst_rdata: assert property (p_rst_rdata) else $error("outputs not clear");
  property p_irq_wr;
    reg_wr && reg_addr == crs_pkg::ADDR_IRQ_ENABLE_MASK |=> irq_enable_q == $past(reg_wdata);
  endproperty
  a_irq_wr: assert property (p_irq_wr) else $error("irq mask write lost");
  property p_boot_run; boot_rd |=> reg_rdata_q[7:5] == 3'b100; endproperty
  a_boot_run: assert property (p_boot_run) else $error("not running after reset");
  property p_boot_cnt; boot_rd |=> reg_rdata_q[4:0] == 5'h0F; endproperty
  a_boot_cnt: assert property (p_boot_cnt) else $error("counter not all ones");
  property p_onehot; st_rd |=> $onehot(reg_rdata_q[7:5]); endproperty
  a_onehot: assert property (p_onehot) else $error("state bits not one-hot");
  property p_done_pulse; cmd_done_q |=> !cmd_done_q; endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("done longer than a cycle");
  property p_errcode; st_rd |=> !reg_rdata_q[4] || reg_rdata_q[3:2] == 2'b00; endproperty
  a_errcode: assert property (p_errcode) else $error("error code out of range");
endmodule // crs_core_monitor

bind crs_core crs_core_monitor #(.DEPTH(DEPTH), .INIT_CYCLES(INIT_CYCLES)) crs_core_monitor_i (
  .clk_sys(clk_sys), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
  .reg_wdata(reg_wdata), .reg_rd(reg_rd), .suspend_req(suspend_req), .sat_evt(sat_evt),
  .burst_en(burst_en), .burst_bytes(burst_bytes), .reg_rdata_q(reg_rdata_q),
  .irq_enable_q(irq_enable_q), .cmd_done_q(cmd_done_q));

// ---- test/crs_host_model.sv ----
`timescale 1ns/10ps
module crs_host_model (
  input wire logic clk_sys, // clock
  input wire logic [7:0] reg_rdata_q, // rdata
  output logic [7:0] reg_addr, // addr
  output logic reg_wr, // write
  output logic [7:0] reg_wdata, // wdata
  output logic reg_rd // read
);
  initial begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_wdata = 8'h00;
    reg_rd = 1'b0;
  end
  // one byte per transaction, so status and readback never share one
  task automatic xfer(input logic wr, input logic [7:0] a, d, output logic [7:0] q);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= wr;
    reg_rd <= !wr;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    // idle lines flip so a stale value never looks valid
    reg_addr <= ~a;
    reg_wdata <= ~d;
    #1;
    q = reg_rdata_q;
  endtask
  task automatic run_cmd(input logic [7:0] code, output logic [7:0] st);
    logic [7:0] s0;
    xfer(1'b0, crs_pkg::ADDR_COMMAND_STATUS, 8'h00, s0);
    xfer(1'b1, crs_pkg::ADDR_COMMAND_CODE, code, st);
    st = s0;
    for (int i = 0; i < 30 && st[4:0] === s0[4:0]; i++) begin
      xfer(1'b0, crs_pkg::ADDR_COMMAND_STATUS, 8'h00, st);
    end
  endtask
endmodule // crs_host_model

// ---- test/tb_command_response_status.sv ----
`timescale 1ns/10ps
module tb_command_response_status;
  localparam logic [7:0] ST = crs_pkg::ADDR_COMMAND_STATUS;
  localparam logic [7:0] RB = crs_pkg::ADDR_PARAM_READBACK;
  localparam logic [7:0] IRQ = crs_pkg::ADDR_IRQ_ENABLE_MASK;
  localparam logic [7:0] HIN = crs_pkg::ADDR_HOST_INPUT;
  localparam int INIT = 8;
  logic clk_sys = 1'b0;
  logic arst_n = 1'b0;
  logic suspend_req = 1'b0;
  logic sat_evt = 1'b0;
  logic burst_en = 1'b0;
  logic [5:0] burst_bytes = 6'h00;
  logic [7:0] reg_addr, reg_wdata, reg_rdata_q, irq_enable_q, q;
  logic reg_wr, reg_rd, cmd_done_q;
  int error_cnt = 0;
  int checks_done = 0;
  int cycles = 0;
  int done_cnt = 0;
  always #10 clk_sys = ~clk_sys;
  crs_core #(.INIT_CYCLES(INIT)) crs_core_i (
    .clk_sys(clk_sys), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .suspend_req(suspend_req), .sat_evt(sat_evt),
    .burst_en(burst_en), .burst_bytes(burst_bytes), .reg_rdata_q(reg_rdata_q),
    .irq_enable_q(irq_enable_q), .cmd_done_q(cmd_done_q));
  crs_host_model crs_host_model_i (
    .clk_sys(clk_sys), .reg_rdata_q(reg_rdata_q), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd));
  task automatic conclude();
    $display("checks_done=%0d error_cnt=%0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cycles++;
    if (cmd_done_q === 1'b1) begin
      done_cnt++;
    end
    if (cycles == 5000) begin
      error_cnt++;
      conclude();
    end
  end
  task automatic cmp8(input logic [7:0] got, exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [7:0] a, m, exp);
    crs_host_model_i.xfer(1'b0, a, 8'h00, q);
    cmp8(q & m, exp);
  endtask
  task automatic wr(input logic [7:0] a, d);
    crs_host_model_i.xfer(1'b1, a, d, q);
  endtask
  task automatic cmd(input logic [7:0] code, exp);
    crs_host_model_i.run_cmd(code, q);
    cmp8(q & 8'h1F, exp);
  endtask
  task automatic poll(input logic [7:0] m, v);
    for (int i = 0; i < 20 && (q & m) !== v; i++) begin
      crs_host_model_i.xfer(1'b0, ST, 8'h00, q);
    end
  endtask
  // wait for the flag, check the code, then clear it
  task automatic err_chk(input logic [4:0] code);
    poll(8'h10, 8'h10);
    rd(ST, 8'hFF, {3'b001, code});
    cmd(crs_pkg::CMD_COUNTER_CLEAR, 8'h00);
    cmp8(irq_enable_q, 8'h3F);
  endtask
  task automatic t_reset();
    rd(ST, 8'hFF, 8'h8F);
    rd(RB, 8'hFF, 8'h00);
    rd(crs_pkg::ADDR_COMMAND_CODE, 8'hFF, 8'h00);
    rd(IRQ, 8'hFF, 8'h00);
    repeat (INIT) @(posedge clk_sys);
    rd(ST, 8'hFF, 8'h2F);
    $display("reset test done");
  endtask
  task automatic t_param();
    int d0;
    d0 = done_cnt;
    wr(HIN, 8'hA5);
    cmd(8'hAB, 8'h00);
    rd(RB, 8'hFF, 8'hA5);
    wr(HIN, 8'h3C);
    cmd(8'h80, 8'h01);
    rd(RB, 8'hFF, 8'h3C);
    cmd(8'h6B, 8'h02);
    rd(RB, 8'hFF, 8'hA5);
    cmp8(8'(done_cnt - d0), 8'h03);
    rd(HIN, 8'hFF, 8'h3C);
    wr(IRQ, 8'h3F);
    cmp8(irq_enable_q, 8'h3F);
    wr(RB, 8'h00);
    rd(RB, 8'hFF, 8'hA5);
    rd(8'h20, 8'hFF, 8'h00);
    $display("param test done");
  endtask
  task automatic t_errors();
    crs_host_model_i.run_cmd(8'hC0, q);
    err_chk(crs_pkg::ERR_INVALID_CMD);
    crs_host_model_i.run_cmd(8'hAC, q);
    err_chk(crs_pkg::ERR_BAD_PARAM);
    @(posedge clk_sys);
    sat_evt <= 1'b1;
    @(posedge clk_sys);
    sat_evt <= 1'b0;
    err_chk(crs_pkg::ERR_SATURATION);
    @(posedge clk_sys);
    burst_en <= 1'b1;
    burst_bytes <= 6'd26;
    rd(ST, 8'hFF, 8'h20);
    @(posedge clk_sys);
    burst_bytes <= 6'd27;
    err_chk(crs_pkg::ERR_OUT_OVERFLOW);
    @(posedge clk_sys);
    burst_en <= 1'b0;
    $display("error test done");
  endtask
  task automatic t_suspend();
    @(posedge clk_sys);
    suspend_req <= 1'b1;
    rd(ST, 8'hFF, 8'h40);
    wr(crs_pkg::ADDR_COMMAND_CODE, 8'h40);
    repeat (6) @(posedge clk_sys);
    rd(ST, 8'hFF, 8'h40);
    @(posedge clk_sys);
    suspend_req <= 1'b0;
    poll(8'h0F, 8'h01);
    rd(ST, 8'h1F, 8'h01);
    rd(RB, 8'hFF, 8'h3C);
    cmd(crs_pkg::CMD_SOFT_RESET, 8'h0F);
    cmp8(irq_enable_q, 8'h00);
    rd(crs_pkg::ADDR_COMMAND_CODE, 8'hFF, 8'h00);
    repeat (INIT) @(posedge clk_sys);
    rd(ST, 8'hFF, 8'h2F);
    $display("suspend and soft reset test done");
  endtask
  // hard reset in mid-run while an error is flagged
  task automatic t_hard_reset();
    wr(IRQ, 8'h15);
    @(posedge clk_sys);
    sat_evt <= 1'b1;
    @(posedge clk_sys);
    sat_evt <= 1'b0;
    poll(8'h10, 8'h10);
    cmp8(q, 8'h32);
    @(posedge clk_sys);
    arst_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    arst_n <= 1'b1;
    rd(ST, 8'hFF, 8'h8F);
    rd(IRQ, 8'hFF, 8'h00);
    cmp8(irq_enable_q, 8'h00);
    repeat (INIT) @(posedge clk_sys);
    rd(ST, 8'hFF, 8'h2F);
    $display("hard reset test done");
  endtask
  initial begin
    repeat (20) @(posedge clk_sys);
    arst_n <= 1'b1;
    t_reset();
    t_param();
    t_errors();
    t_suspend();
    t_hard_reset();
    conclude();
  end
endmodule // tb_command_response_status
